// ==== design/iisc_consts.vh ====
/*
 * Constants for the interrupt status and clear block: register offsets,
 * field positions, reset values and widths.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef IISC_CONSTS_VH
`define IISC_CONSTS_VH

// ****************************************************************
// Register offsets, byte addresses on the register port
// ****************************************************************
`define IISC_OFF_MASKED_STAT 8'h2c
`define IISC_OFF_EVENT_MASK 8'h30
`define IISC_OFF_RAW_EVENTS 8'h34
`define IISC_OFF_RX_THRESH 8'h38
`define IISC_OFF_TX_THRESH 8'h3c
`define IISC_OFF_CLR_ALL 8'h40
`define IISC_OFF_CLEAR_UNDERFLOW_BIT 8'h44
`define IISC_OFF_CLEAR_OVERFLOW_BIT 8'h48
`define IISC_OFF_CLEAR_TRANSMIT_OVERFLOW_BIT 8'h4c
`define IISC_OFF_CLEAR_READ_REQUEST_BIT 8'h50
`define IISC_OFF_ABORT_CAUSE 8'h80

// ****************************************************************
// Field positions in the event registers
// ****************************************************************
`define IISC_BIT_GENERAL_CALL_FLAG 11
`define IISC_BIT_START 10
`define IISC_BIT_STOP 9
`define IISC_BIT_ACTIVITY 8
`define IISC_BIT_SLV_TX_DONE 7
`define IISC_BIT_TX_ABORT 6
`define IISC_BIT_RD_REQ 5
`define IISC_BIT_TX_LOW 4
`define IISC_BIT_TX_OVER 3
`define IISC_BIT_RX_FULL 2
`define IISC_BIT_RX_OVER 1
`define IISC_BIT_RX_UNDER 0

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define IISC_NUM_EVENTS 12
`define IISC_ADDR_W 8
`define IISC_DATA_W 32
`define IISC_THRESH_W 8
`define IISC_CAUSE_W 16
`define IISC_MASK_RESET 12'h8ff
`define IISC_EVENTS_RESET 12'h000
`define IISC_THRESH_RESET 8'h00
`define IISC_CAUSE_RESET 16'h0000
`define IISC_DATA_ZERO 32'h0000_0000
`define IISC_LEVEL_EVENTS 12'h014

`endif

// ==== design/iisc_flag.v ====
/*
 * One sticky event flag with a set input and a clear input.
 * Assumes set and clear are synchronous to clk_i; set wins over clear.
 */
module iisc_flag (
    // Clock and reset.
    input wire clk_i,
    input wire rst_n_i,
    // Control.
    input wire set_i,
    input wire clear_i,
    // State.
    output reg flag_o
);

    // ****************************************************************
    // Flag storage
    // ****************************************************************
    // An event in the cycle of its clear must not be lost, so set wins.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_o <= 1'b0;
        end else if (set_i) begin
            flag_o <= 1'b1;
        end else if (clear_i) begin
            flag_o <= 1'b0;
        end
    end

endmodule // iisc_flag

// ==== design/iisc_top.v ====
/*
 * Interrupt status, threshold and read-to-clear logic of a two-wire
 * serial bus controller, with its register port.
 * Assumes the bus engine and FIFOs outside give one-cycle event pulses
 * and fill levels synchronous to clk_i, and a single-cycle register port.
 */
`include "iisc_consts.vh"

module iisc_top (
    // Clock and reset.
    input wire clk_i,
    input wire rst_n_i,
    // Register port.
    input wire [7:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    // Bus condition events from the bus engine.
    input wire general_call_flag_addr_i,
    input wire general_call_flag_acked_i,
    input wire start_seen_i,
    input wire stop_seen_i,
    input wire bus_active_i,
    input wire slave_tx_i,
    input wire master_nack_i,
    input wire transmit_abort_i,
    input wire [15:0] abort_cause_i,
    input wire read_request_i,
    // Transmit FIFO state.
    input wire [7:0] tx_fifo_level_i,
    input wire tx_fifo_full_i,
    input wire data_command_write_i,
    // Receive FIFO state.
    input wire [7:0] rx_fifo_level_i,
    input wire rx_fifo_full_i,
    input wire rx_fifo_empty_i,
    input wire rx_byte_in_i,
    input wire data_command_read_i,
    // Thresholds and status out.
    output reg [7:0] receive_threshold_o,
    output reg [7:0] transmit_threshold_o,
    output reg [15:0] abort_cause_register_o,
    output wire [11:0] raw_events_o,
    output wire [11:0] masked_status_o,
    output wire intr_o
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function hit;
        input [7:0] addr;
        input [7:0] offset;
        begin
            hit = (addr == offset);
        end
    endfunction

    function [31:0] word_of;
        input [11:0] bits;
        begin
            word_of = {20'h0_0000, bits};
        end
    endfunction

    // ****************************************************************
    // Register file state
    // ****************************************************************
    reg [11:0] event_mask;
    reg tx_low_flag;
    reg rx_full_flag;
    wire [11:0] sticky_flags;
    wire [11:0] raw_events;
    wire [11:0] masked_status;
    wire combined;

    // ****************************************************************
    // Read strobes of the clear registers
    // ****************************************************************
    wire rd_clr_all;
    wire rd_clear_underflow_bit;
    wire rd_clear_overflow_bit;
    wire rd_clear_transmit_overflow_bit;
    wire rd_clear_read_request_bit;

    assign rd_clr_all = rd_i && hit(addr_i, `IISC_OFF_CLR_ALL);
    assign rd_clear_underflow_bit = rd_i && hit(addr_i, `IISC_OFF_CLEAR_UNDERFLOW_BIT);
    assign rd_clear_overflow_bit = rd_i && hit(addr_i, `IISC_OFF_CLEAR_OVERFLOW_BIT);
    assign rd_clear_transmit_overflow_bit = rd_i && hit(addr_i, `IISC_OFF_CLEAR_TRANSMIT_OVERFLOW_BIT);
    assign rd_clear_read_request_bit = rd_i && hit(addr_i, `IISC_OFF_CLEAR_READ_REQUEST_BIT);

    // ****************************************************************
    // Event set and clear vectors
    // ****************************************************************
    reg [11:0] set_vec;
    reg [11:0] clr_vec;

    always @* begin
        set_vec = `IISC_EVENTS_RESET;
        // A general call that is not acknowledged leaves no trace.
        set_vec[`IISC_BIT_GENERAL_CALL_FLAG] = general_call_flag_addr_i && general_call_flag_acked_i;
        set_vec[`IISC_BIT_START] = start_seen_i;
        set_vec[`IISC_BIT_STOP] = stop_seen_i;
        // Held set while the bus is busy, so a clear cannot win then.
        set_vec[`IISC_BIT_ACTIVITY] = bus_active_i;
        set_vec[`IISC_BIT_SLV_TX_DONE] = slave_tx_i && master_nack_i;
        set_vec[`IISC_BIT_TX_ABORT] = transmit_abort_i;
        set_vec[`IISC_BIT_RD_REQ] = read_request_i;
        set_vec[`IISC_BIT_TX_OVER] = data_command_write_i && tx_fifo_full_i;
        set_vec[`IISC_BIT_RX_OVER] = rx_byte_in_i && rx_fifo_full_i;
        set_vec[`IISC_BIT_RX_UNDER] = data_command_read_i && rx_fifo_empty_i;
    end

    always @* begin
        clr_vec = {12{rd_clr_all}};
        clr_vec[`IISC_BIT_RX_UNDER] = rd_clr_all || rd_clear_underflow_bit;
        clr_vec[`IISC_BIT_RX_OVER] = rd_clr_all || rd_clear_overflow_bit;
        clr_vec[`IISC_BIT_TX_OVER] = rd_clr_all || rd_clear_transmit_overflow_bit;
        clr_vec[`IISC_BIT_RD_REQ] = rd_clr_all || rd_clear_read_request_bit;
    end

    // ****************************************************************
    // Sticky event flags
    // ****************************************************************
    // The two threshold bits are levels; their cells are never set and
    // their positions are filled from the level flops instead.
    genvar gi;
    generate
        for (gi = 0; gi < `IISC_NUM_EVENTS; gi = gi + 1) begin : g_flag
            iisc_flag u_flag (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .set_i(set_vec[gi]),
                .clear_i(clr_vec[gi]),
                .flag_o(sticky_flags[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // Threshold level flags
    // ****************************************************************
    // These follow the fill level and cannot be cleared by software;
    // they drop only when the fill level or a write of the threshold register takes the FIFO past the threshold.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_low_flag <= 1'b0;
            rx_full_flag <= 1'b0;
        end else begin
            tx_low_flag <= (tx_fifo_level_i <= transmit_threshold_o);
            rx_full_flag <= (rx_fifo_level_i >= receive_threshold_o);
        end
    end

    assign raw_events = (sticky_flags & ~`IISC_LEVEL_EVENTS)
        | ({11'h000, tx_low_flag} << `IISC_BIT_TX_LOW)
        | ({11'h000, rx_full_flag} << `IISC_BIT_RX_FULL);

    // ****************************************************************
    // Masking and combined interrupt
    // ****************************************************************
    assign masked_status = raw_events & event_mask;
    assign combined = |masked_status;
    assign raw_events_o = raw_events;
    assign masked_status_o = masked_status;
    assign intr_o = combined;

    // ****************************************************************
    // Writable registers
    // ****************************************************************
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            event_mask <= `IISC_MASK_RESET;
            receive_threshold_o <= `IISC_THRESH_RESET;
            transmit_threshold_o <= `IISC_THRESH_RESET;
        end else if (wr_i) begin
            if (hit(addr_i, `IISC_OFF_EVENT_MASK)) begin
                event_mask <= wdata_i[11:0];
            end else if (hit(addr_i, `IISC_OFF_RX_THRESH)) begin
                receive_threshold_o <= wdata_i[7:0];
            end else if (hit(addr_i, `IISC_OFF_TX_THRESH)) begin
                transmit_threshold_o <= wdata_i[7:0];
            end
        end
    end

    // ****************************************************************
    // Abort cause register
    // ****************************************************************
    // Causes accumulate until the global clear; a new cause in the clear
    // cycle survives it.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            abort_cause_register_o <= `IISC_CAUSE_RESET;
        end else if (transmit_abort_i) begin
            if (rd_clr_all) begin
                abort_cause_register_o <= abort_cause_i;
            end else begin
                abort_cause_register_o <= abort_cause_register_o | abort_cause_i;
            end
        end else if (rd_clr_all) begin
            abort_cause_register_o <= `IISC_CAUSE_RESET;
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    // Clear registers return in bit 0 the state they are clearing, taken
    // before the clear lands. Unmapped offsets read as zero.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= `IISC_DATA_ZERO;
        end else if (rd_i) begin
            if (hit(addr_i, `IISC_OFF_MASKED_STAT)) begin
                rdata_o <= word_of(masked_status);
            end else if (hit(addr_i, `IISC_OFF_EVENT_MASK)) begin
                rdata_o <= word_of(event_mask);
            end else if (hit(addr_i, `IISC_OFF_RAW_EVENTS)) begin
                rdata_o <= word_of(raw_events);
            end else if (hit(addr_i, `IISC_OFF_RX_THRESH)) begin
                rdata_o <= {24'h00_0000, receive_threshold_o};
            end else if (hit(addr_i, `IISC_OFF_TX_THRESH)) begin
                rdata_o <= {24'h00_0000, transmit_threshold_o};
            end else if (rd_clr_all) begin
                rdata_o <= {31'h0000_0000, combined};
            end else if (rd_clear_underflow_bit) begin
                rdata_o <= {31'h0000_0000, raw_events[`IISC_BIT_RX_UNDER]};
            end else if (rd_clear_overflow_bit) begin
                rdata_o <= {31'h0000_0000, raw_events[`IISC_BIT_RX_OVER]};
            end else if (rd_clear_transmit_overflow_bit) begin
                rdata_o <= {31'h0000_0000, raw_events[`IISC_BIT_TX_OVER]};
            end else if (rd_clear_read_request_bit) begin
                rdata_o <= {31'h0000_0000, raw_events[`IISC_BIT_RD_REQ]};
            end else if (hit(addr_i, `IISC_OFF_ABORT_CAUSE)) begin
                rdata_o <= {16'h0000, abort_cause_register_o};
            end else begin
                rdata_o <= `IISC_DATA_ZERO;
            end
        end else begin
            rdata_o <= `IISC_DATA_ZERO;
        end
    end

endmodule // iisc_top

// ==== bench/iisc_top_chk.sv ====
/*
 * Port-level assertions for the interrupt status and clear block.
 * Assumes it is bound to iisc_top and sees only that module's ports.
 */
module iisc_top_chk (
    // Clock and reset.
    input logic clk_i,
    input logic rst_n_i,
    // Register port.
    input logic [7:0] addr_i,
    input logic rd_i,
    // Event and FIFO inputs.
    input logic start_seen_i,
    input logic stop_seen_i,
    input logic bus_active_i,
    input logic transmit_abort_i,
    input logic [7:0] tx_fifo_level_i,
    input logic rx_fifo_full_i,
    input logic rx_byte_in_i,
    input logic [7:0] rx_fifo_level_i,
    // Outputs watched.
    input logic [7:0] receive_threshold_o,
    input logic [7:0] transmit_threshold_o,
    input logic [15:0] abort_cause_register_o,
    input logic [11:0] raw_events_o,
    input logic [11:0] masked_status_o,
    input logic intr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // ********
    // Clear reads
    // ********
    sequence s_clr(logic [7:0] a);
        rd_i && addr_i == a;
    endsequence
    clr_over_a: assert property (s_clr(8'h48) ##0 !(rx_byte_in_i && rx_fifo_full_i)
        |=> !raw_events_o[1]) else $error("overflow flag survived its clear read");
    clr_all_a: assert property (s_clr(8'h40) ##0 !transmit_abort_i
        |=> abort_cause_register_o == 16'h0000) else $error("abort cause kept after clear");

    // ********
    // Event flags
    // ********
    rx_over_a: assert property (rx_byte_in_i && rx_fifo_full_i |=> raw_events_o[1])
        else $error("receive overflow not flagged");
    start_a: assert property (start_seen_i |=> raw_events_o[10])
        else $error("start not flagged");
    stop_a: assert property (stop_seen_i |=> raw_events_o[9])
        else $error("stop not flagged");
    act_a: assert property (bus_active_i |=> raw_events_o[8])
        else $error("activity not flagged");
    // The threshold flags lag their inputs by one cycle, so the past values decide.
    tx_low_a: assert property (1'b1 |=> raw_events_o[4] ==
        ($past(tx_fifo_level_i) <= $past(transmit_threshold_o))) else $error("tx low wrong");
    rx_full_a: assert property (1'b1 |=> raw_events_o[2] ==
        ($past(rx_fifo_level_i) >= $past(receive_threshold_o))) else $error("rx full wrong");
    intr_a: assert property (intr_o == |masked_status_o
        && (masked_status_o & ~raw_events_o) == 12'h000) else $error("masked status wrong");
endmodule // iisc_top_chk

bind iisc_top iisc_top_chk u_iisc_top_chk (.*);

// ==== bench/iisc_bus_model.sv ====
/*
 * Model of the bus engine and FIFOs that feed the block's event inputs.
 * Assumes the bench requests one event code per go pulse.
 */
module iisc_bus_model (
    // Clock.
    input logic clk_i,
    // Requests from the bench.
    input logic go_i,
    input logic [3:0] code_i,
    input logic [15:0] cause_i,
    // Event lines towards the block.
    output logic [14:0] ev_o = 15'h0000,
    output logic [15:0] abort_cause_o = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ns;
    // Every event is a one-cycle pulse; a stale cause is inverted so it is never reused.
    always @(posedge clk_i) begin
        abort_cause_o <= go_i ? cause_i : ~abort_cause_o;
        ev_o <= 15'h0000;
        if (go_i) begin
            case (code_i)
                4'h0: ev_o <= 15'h6000;
                4'h1: ev_o <= 15'h1000;
                4'h2: ev_o <= 15'h0800;
                4'h3: ev_o <= 15'h0400;
                4'h4: ev_o <= 15'h0300;
                4'h5: ev_o <= 15'h0080;
                4'h6: ev_o <= 15'h0040;
                4'h7: ev_o <= 15'h0030;
                4'h8: ev_o <= 15'h000c;
                4'h9: ev_o <= 15'h0003;
                4'ha: ev_o <= 15'h4000;
                4'hb: ev_o <= 15'h0100;
                default: ev_o <= 15'h0004;
            endcase
        end
    end
endmodule // iisc_bus_model

// ==== bench/iisc_top_tb_top.sv ====
/*
 * Self-checking bench for the interrupt status and clear block.
 * Assumes the bus model drives every event input and the bench the rest.
 */
module iisc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, go = 0, rd_seen = 0;
    logic [7:0] addr_i = 8'h00, tx_fifo_level_i = 8'h00, rx_fifo_level_i = 8'h00;
    logic [31:0] wdata_i = 32'h0000_0000, rdata_o;
    logic [3:0] code = 4'h0;
    logic [15:0] cause = 16'h0000, abort_cause_i, abort_cause_register_o;
    logic [14:0] ev;
    logic [7:0] receive_threshold_o, transmit_threshold_o;
    logic [11:0] raw_events_o, masked_status_o;
    logic intr_o, general_call_flag_addr_i, general_call_flag_acked_i, start_seen_i, stop_seen_i, bus_active_i;
    logic slave_tx_i, master_nack_i, transmit_abort_i, read_request_i, tx_fifo_full_i;
    logic data_command_write_i, rx_fifo_full_i, rx_byte_in_i, rx_fifo_empty_i;
    logic data_command_read_i;
    int mismatches = 0, compares = 0;
    int bit_of[13] = '{11, 10, 9, 8, 7, 6, 5, 3, 1, 0, -1, -1, -1};
    logic [63:0] exp_q[$];
    assign {general_call_flag_addr_i, general_call_flag_acked_i, start_seen_i, stop_seen_i, bus_active_i,
        slave_tx_i, master_nack_i, transmit_abort_i, read_request_i, tx_fifo_full_i,
        data_command_write_i, rx_fifo_full_i, rx_byte_in_i, rx_fifo_empty_i,
        data_command_read_i} = ev;
    iisc_top u_iisc_top (.*);
    iisc_bus_model u_iisc_bus_model (.clk_i(clk_i), .go_i(go), .code_i(code),
        .cause_i(cause), .ev_o(ev), .abort_cause_o(abort_cause_i));

    // ********
    // Clock, checking and closing
    // ********
    initial forever #50 clk_i = ~clk_i;
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
    always @(posedge clk_i) rd_seen <= rd_i;
    always @(negedge clk_i) begin
        logic [63:0] e;
        if (rd_seen) begin
            e = exp_q.pop_front();
            check(rdata_o & e[63:32], e[31:0]);
        end
    end
    initial begin
        #1000000;
        mismatches++;
        tally_and_finish();
    end

    // ********
    // Bus tasks
    // ********
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        exp_q.push_back({m, e});
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic fire(input logic [3:0] c, input logic [15:0] cv);
        @(posedge clk_i);
        go <= 1'b1;
        code <= c;
        cause <= cv;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    // ********
    // Scenarios
    // ********
    initial begin
        logic [7:0] tl, rl, tv, rv, ca;
        logic [11:0] m, e;
        logic [15:0] cv;
        void'($urandom(41292));
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(8'h30, 32'hffff_ffff, 32'h0000_08ff);
        rd(8'h38, 32'hffff_ffff, 32'h0000_0000);
        rd(8'h3c, 32'hffff_ffff, 32'h0000_0000);
        rd(8'h20, 32'hffff_ffff, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            tl = $urandom % 8;
            rl = $urandom % 8;
            tv = $urandom % 8;
            rv = $urandom % 8;
            wr(8'h3c, ($urandom & 32'hffff_ff00) | tl);
            wr(8'h38, ($urandom & 32'hffff_ff00) | rl);
            tx_fifo_level_i <= tv;
            rx_fifo_level_i <= rv;
            rd(8'h38, 32'hffff_ffff, rl);
            rd(8'h3c, 32'hffff_ffff, tl);
            rd(8'h34, 32'hffff_ffff, {(tv <= tl), 1'b0, (rv >= rl), 2'b00});
        end
        wr(8'h3c, 32'h0000_0000);
        wr(8'h38, 32'h0000_0010);
        tx_fifo_level_i <= 8'h05;
        rx_fifo_level_i <= 8'h03;
        for (int k = 0; k < 13; k++) begin
            e = bit_of[k] < 0 ? 12'h000 : 12'h001 << bit_of[k];
            m = $urandom;
            cv = $urandom | 1;
            wr(8'h30, m);
            fire(k, cv);
            rd(8'h34, 32'hffff_ffff, e);
            rd(8'h2c, 32'hffff_ffff, e & m);
            rd(8'h80, 32'hffff_ffff, k == 5 ? cv : 16'h0000);
            ca = e[0] ? 8'h44 : e[1] ? 8'h48 : e[3] ? 8'h4c : e[5] ? 8'h50 : 8'h40;
            rd(ca, 32'hffff_ffff, ca == 8'h40 ? |(e & m) : 1'b1);
            rd(8'h34, 32'hffff_ffff, 32'h0000_0000);
            rd(8'h80, 32'hffff_ffff, 32'h0000_0000);
        end
        // A reset in mid-run must bring the mask and thresholds back to their reset values.
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(8'h30, 32'hffff_ffff, 32'h0000_08ff);
        rd(8'h38, 32'hffff_ffff, 32'h0000_0000);
        rd(8'h3c, 32'hffff_ffff, 32'h0000_0000);
        rd(8'h80, 32'hffff_ffff, 32'h0000_0000);
        repeat (3) @(posedge clk_i);
        tally_and_finish();
    end
endmodule // iisc_top_tb_top
